// ===== src/hs_ctrl.v
// peripheral-side controller driving the buffer's handshake port under APB control
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hs_ctrl_map.vh"

module hs_ctrl (
   // clock and reset
   input  wire        CLK_SYS,
   input  wire        RST,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   output wire        IRQ,
   // data bus
   input  wire [7:0]  DATA_IN,
   output reg  [7:0]  DATA_OUT,
   output reg         DATA_OE,
   output reg         OE_N,
   // handshake lines
   input  wire        READY_OR_AVAILABLE_OUT,
   output reg         VALID_OR_ACCEPTED_IN,
   input  wire        ACCEPTED_OR_LISTENER_READY_IN,
   output reg         ACCEPTED_OR_LISTENER_READY_OUT,
   output reg         ACCEPTED_OR_LISTENER_READY_OE,
   // flags and control lines
   input  wire        FULL,
   input  wire        EMPTY,
   input  wire        CLEAR_IN,
   output wire        CLEAR_OUT,
   output reg         CLEAR_OE,
   input  wire        DATA_DIR_IN,
   output reg         DATA_DIR_OUT,
   output reg         DATA_DIR_OE,
   // general purpose lines
   output reg         GENERAL_INPUT_BIT0,
   input  wire        GENERAL_OUTPUT_BIT1,
   input  wire        GENERAL_OUTPUT_BIT3
);
   // ****************************************
   // states
   // ****************************************
   localparam [5:0] S_IDLE     = 6'b00_0001;
   localparam [5:0] S_TX_SETUP = 6'b00_0010;
   localparam [5:0] S_TX_STRB  = 6'b00_0100;
   localparam [5:0] S_TX_REL   = 6'b00_1000;
   localparam [5:0] S_RX_WAIT  = 6'b01_0000;
   localparam [5:0] S_RX_ACK   = 6'b10_0000;
   localparam integer SETUP_INT = `DATA_SETUP_CYC;
   localparam [2:0] SETUP_CYC  = SETUP_INT[2:0];

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [15:0] pins_s;
   pin_sync #(.W(16)) u_sync (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .D       ({DATA_IN, READY_OR_AVAILABLE_OUT, ACCEPTED_OR_LISTENER_READY_IN, FULL, EMPTY,
                 CLEAR_IN, DATA_DIR_IN, GENERAL_OUTPUT_BIT1, GENERAL_OUTPUT_BIT3}),
      .Q       (pins_s)
   );
   wire [7:0] data_s  = pins_s[15:8];
   wire       rdy_s   = pins_s[7];
   wire       third_s = pins_s[6];
   wire       full_s  = pins_s[5];
   wire       empty_s = pins_s[4];
   wire       clr_s   = pins_s[3];
   wire       dir_s   = pins_s[2];
   wire       general_output_bit1_s  = pins_s[1];
   wire       general_output_bit3_s  = pins_s[0];

   // ****************************************
   // registers
   // ****************************************
   reg [`CTRL_W-1:0] ctrl_r;
   reg [7:0]         tx_data_r;
   reg               tx_pend_r;
   reg [7:0]         rx_data_r;
   reg               rx_valid_r;
   reg [`IRQ_W-1:0]  int_stat_r;
   reg [`IRQ_W-1:0]  int_mask_r;
   reg [5:0]         state_r;
   reg [5:0]         state_nxt;
   reg [2:0]         cnt_r;
   reg               full_d_r;
   reg               empty_d_r;
   reg [1:0]         oe_age_r;
   reg [2:0]         live_r;

   wire en        = ctrl_r[`CTRL_EN];
   wire dir_tx    = ctrl_r[`CTRL_DIR_TX];
   wire two_wire  = ctrl_r[`CTRL_TWO_WIRE];
   // a clear from either end aborts the transfer in progress
   wire clearing  = ctrl_r[`CTRL_CLEAR] | ~clr_s;
   wire run       = en & ~clearing;

   wire wr_acc    = PSEL & PENABLE & PWRITE;
   wire rd_acc    = PSEL & PENABLE & ~PWRITE;
   wire rd_setup  = PSEL & ~PENABLE & ~PWRITE;
   wire tx_refuse = (state_r != S_IDLE) | tx_pend_r;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `OFS_CTRL) | (a == `OFS_TXDATA) | (a == `OFS_STATUS) |
                  (a == `OFS_RXDATA) | (a == `OFS_INT_STAT) | (a == `OFS_INT_MASK);
      end
   endfunction

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & (~mapped(PADDR) | (PWRITE & (PADDR == `OFS_TXDATA) & tx_refuse));
   assign IRQ     = |(int_stat_r & int_mask_r);
   // open-drain style: only ever pulled low
   assign CLEAR_OUT = 1'b0;

   wire [8:0] status = {rdy_s, clr_s, dir_s, general_output_bit3_s, general_output_bit1_s, empty_s, full_s,
                        rx_valid_r, (state_r != S_IDLE) | tx_pend_r};

   // ****************************************
   // handshake sequencer
   // ****************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (run & dir_tx & tx_pend_r & rdy_s)
               state_nxt = S_TX_SETUP;
            // the synchronised bus shows the device's byte only some cycles after its drivers turn on
            else if (run & ~dir_tx & ~rx_valid_r & (oe_age_r == 2'd3))
               state_nxt = S_RX_WAIT;
         end
         S_TX_SETUP: begin
            if (cnt_r == 3'd0)
               state_nxt = S_TX_STRB;
         end
         S_TX_STRB: begin
            if (two_wire ? ~rdy_s : third_s)
               state_nxt = S_TX_REL;
         end
         S_TX_REL: begin
            if (two_wire | ~third_s)
               state_nxt = S_IDLE;
         end
         S_RX_WAIT: begin
            if (~rdy_s)
               state_nxt = S_RX_ACK;
         end
         S_RX_ACK: begin
            if (rdy_s)
               state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
      if (~run)
         state_nxt = S_IDLE;
   end

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_r  <= S_IDLE;
         cnt_r    <= 3'd0;
         oe_age_r <= 2'd0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == S_TX_SETUP && state_r != S_TX_SETUP)
            cnt_r <= SETUP_CYC - 3'd1;
         else if (cnt_r != 3'd0)
            cnt_r <= cnt_r - 3'd1;
         if (OE_N)
            oe_age_r <= 2'd0;
         else if (oe_age_r != 2'd3)
            oe_age_r <= oe_age_r + 2'd1;
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         DATA_OUT                       <= 8'h00;
         DATA_OE                        <= 1'b0;
         OE_N                           <= 1'b1;
         VALID_OR_ACCEPTED_IN           <= 1'b1;
         ACCEPTED_OR_LISTENER_READY_OUT <= 1'b0;
         ACCEPTED_OR_LISTENER_READY_OE  <= 1'b0;
         CLEAR_OE                       <= 1'b0;
         DATA_DIR_OUT                   <= 1'b0;
         DATA_DIR_OE                    <= 1'b0;
         GENERAL_INPUT_BIT0             <= 1'b0;
      end else begin
         DATA_OUT <= tx_data_r;
         // data held through the release phase to cover the device's hold time
         DATA_OE  <= (state_nxt == S_TX_SETUP) | (state_nxt == S_TX_STRB) | (state_nxt == S_TX_REL);
         OE_N     <= ~(run & ~dir_tx);
         if (two_wire)
            VALID_OR_ACCEPTED_IN <= ~((state_nxt == S_TX_STRB) | (state_nxt == S_RX_ACK));
         else if (dir_tx)
            VALID_OR_ACCEPTED_IN <= ~(state_nxt == S_TX_STRB);
         else
            VALID_OR_ACCEPTED_IN <= (state_nxt == S_RX_ACK);
         ACCEPTED_OR_LISTENER_READY_OE  <= ~two_wire & ~dir_tx;
         ACCEPTED_OR_LISTENER_READY_OUT <= (state_nxt == S_RX_WAIT);
         CLEAR_OE           <= ctrl_r[`CTRL_CLEAR];
         DATA_DIR_OE        <= ctrl_r[`CTRL_DRIVE_DIR];
         DATA_DIR_OUT       <= dir_tx;
         GENERAL_INPUT_BIT0 <= ctrl_r[`CTRL_GEN_IN];
      end
   end

   // ****************************************
   // register file
   // ****************************************
   wire tx_done = (state_r == S_TX_REL) & (state_nxt == S_IDLE) & run;
   wire rx_cap  = (state_r == S_RX_WAIT) & (state_nxt == S_RX_ACK);
   wire rx_done = (state_r == S_RX_ACK) & (state_nxt == S_IDLE) & run;
   // flag edges count only once the synchronisers hold real pin levels, so reset gives no false event
   wire [`IRQ_W-1:0] ev = {empty_s & ~empty_d_r & live_r[2], full_s & ~full_d_r & live_r[2], rx_done, tx_done};

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ctrl_r     <= `CTRL_RST;
         tx_data_r  <= 8'h00;
         tx_pend_r  <= 1'b0;
         rx_data_r  <= 8'h00;
         rx_valid_r <= 1'b0;
         int_stat_r <= `IRQ_RST;
         int_mask_r <= `IRQ_RST;
         full_d_r   <= 1'b0;
         empty_d_r  <= 1'b0;
         live_r     <= 3'd0;
         PRDATA     <= 32'h0000_0000;
      end else begin
         full_d_r  <= full_s;
         empty_d_r <= empty_s;
         live_r    <= {live_r[1:0], 1'b1};
         if (wr_acc && PADDR == `OFS_CTRL)
            ctrl_r <= PWDATA[`CTRL_W-1:0];
         if (wr_acc && PADDR == `OFS_INT_MASK)
            int_mask_r <= PWDATA[`IRQ_W-1:0];
         if (wr_acc && PADDR == `OFS_TXDATA && !tx_refuse) begin
            tx_data_r <= PWDATA[7:0];
            tx_pend_r <= 1'b1;
         end else if (state_r == S_TX_SETUP || clearing)
            tx_pend_r <= 1'b0;
         if (rx_cap) begin
            rx_data_r  <= data_s;
            rx_valid_r <= 1'b1;
         end else if ((rd_acc && PADDR == `OFS_RXDATA) || clearing)
            rx_valid_r <= 1'b0;
         // a new event wins over a write-one clear in the same cycle
         if (wr_acc && PADDR == `OFS_INT_STAT)
            int_stat_r <= (int_stat_r & ~PWDATA[`IRQ_W-1:0]) | ev;
         else
            int_stat_r <= int_stat_r | ev;
         if (rd_setup) begin
            case (PADDR)
               `OFS_CTRL:     PRDATA <= {26'h000_0000, ctrl_r};
               `OFS_TXDATA:   PRDATA <= {24'h00_0000, tx_data_r};
               `OFS_STATUS:   PRDATA <= {23'h00_0000, status};
               `OFS_RXDATA:   PRDATA <= {24'h00_0000, rx_data_r};
               `OFS_INT_STAT: PRDATA <= {28'h000_0000, int_stat_r};
               `OFS_INT_MASK: PRDATA <= {28'h000_0000, int_mask_r};
               default:       PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // hs_ctrl

`default_nettype wire

// ===== src/hs_ctrl_map.vh
// offsets, field positions, reset values and timing counts of the handshake controller
`ifndef HS_CTRL_MAP_VH
`define HS_CTRL_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CTRL       8'h00
`define OFS_TXDATA     8'h04
`define OFS_STATUS     8'h08
`define OFS_RXDATA     8'h0C
`define OFS_INT_STAT   8'h10
`define OFS_INT_MASK   8'h14

// ****************************************
// control fields
// ****************************************
`define CTRL_EN        0
`define CTRL_DIR_TX    1
`define CTRL_TWO_WIRE  2
`define CTRL_CLEAR     3
`define CTRL_DRIVE_DIR 4
`define CTRL_GEN_IN    5
`define CTRL_W         6
`define CTRL_RST       6'h00

// ****************************************
// status fields
// ****************************************
`define ST_BUSY        0
`define ST_RX_VALID    1
`define ST_FULL        2
`define ST_EMPTY       3
`define ST_GEN_GENERAL_OUTPUT_BIT1    4
`define ST_GEN_GENERAL_OUTPUT_BIT3    5
`define ST_DIR_PIN     6
`define ST_CLEAR_PIN   7
`define ST_READY_PIN   8

// ****************************************
// interrupt fields
// ****************************************
`define IRQ_TX_DONE    0
`define IRQ_RX_DONE    1
`define IRQ_FULL       2
`define IRQ_EMPTY      3
`define IRQ_W          4
`define IRQ_RST        4'h0

// ****************************************
// timing
// ****************************************
`define CLK_MHZ        50
`define DATA_SETUP_NS  100
`define DATA_SETUP_CYC ((`DATA_SETUP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== src/pin_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         CLK_SYS,
   input  wire         RST,
   // pins in, synchronised out
   input  wire [W-1:0] D,
   output wire [W-1:0] Q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= D;
         sync_r <= meta_r;
      end
   end

   assign Q = sync_r;
endmodule // pin_sync

`default_nettype wire

// ===== tb/hs_ctrl_asserts.sv
// port checker of the handshake controller
`timescale 1ns/1ps
`default_nettype none
module hs_ctrl_asserts (
   // clock and reset
   input wire       CLK_SYS,
   input wire       RST,
   // apb
   input wire       PSEL,
   input wire       PENABLE,
   input wire       PSLVERR,
   // data bus
   input wire [7:0] DATA_OUT,
   input wire       DATA_OE,
   input wire       OE_N,
   // handshake and control lines
   input wire       READY_OR_AVAILABLE_OUT,
   input wire       VALID_OR_ACCEPTED_IN,
   input wire       ACCEPTED_OR_LISTENER_READY_IN,
   input wire       ACCEPTED_OR_LISTENER_READY_OE,
   input wire       CLEAR_OUT,
   input wire       CLEAR_OE,
   input wire       DATA_DIR_OUT
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   bus_excl_a: assert property (DATA_OE |-> OE_N)
      else $error("both sides drive the data bus");
   err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error outside access phase");
   data_setup_a: assert property ($rose(DATA_OE) |-> VALID_OR_ACCEPTED_IN [*4] ##[1:2] !VALID_OR_ACCEPTED_IN)
      else $error("strobe not after data setup");
   data_hold_a: assert property (DATA_OE && $past(DATA_OE) |-> $stable(DATA_OUT))
      else $error("data changed within a transfer");
   rel_after_ack_a: assert property (DATA_OE && $rose(VALID_OR_ACCEPTED_IN) |->
      $past(ACCEPTED_OR_LISTENER_READY_IN, 3) || !$past(READY_OR_AVAILABLE_OUT, 3))
      else $error("strobe released before response");
   dir_tx_a: assert property (DATA_OE |-> DATA_DIR_OUT)
      else $error("driving bus with direction out");
   dir_rx_a: assert property (!OE_N |-> !DATA_DIR_OUT)
      else $error("device enabled with direction in");
   clear_low_a: assert property (CLEAR_OE |-> !CLEAR_OUT && !DATA_OE)
      else $error("clear driven high or transfer kept running");
   lsn_dir_a: assert property (ACCEPTED_OR_LISTENER_READY_OE |-> !DATA_OE && !DATA_DIR_OUT)
      else $error("listener line driven while sending");
   rx_accept_a: assert property (ACCEPTED_OR_LISTENER_READY_OE && $rose(VALID_OR_ACCEPTED_IN) |->
      !$past(READY_OR_AVAILABLE_OUT, 3))
      else $error("accepted before byte available");
   cover property ($rose(DATA_OE));
   cover property (ACCEPTED_OR_LISTENER_READY_OE && $rose(VALID_OR_ACCEPTED_IN));
   cover property (PSLVERR);
endmodule // hs_ctrl_asserts
bind hs_ctrl hs_ctrl_asserts u_chk (.*);
`default_nettype wire

// ===== tb/fifo_dev_model.sv
// behavioural model of the buffer device at its peripheral port
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model #(
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // model settings: slow answers, two-wire mode, control register 3
   input  wire logic       dly,
   input  wire logic       two,
   input  wire logic [3:0] c3w,
   // pins
   input  wire logic [7:0] bus,
   input  wire logic       oe_n,
   input  wire logic       ack,
   input  wire logic       lrdy,
   input  wire logic       clr_n,
   input  wire logic       dir,
   input  wire logic       gin,
   output logic            rdy,
   output logic            dac,
   output logic      [7:0] dq,
   output logic            full,
   output logic            empty,
   output logic      [3:0] c3r
);
   // ****************************************
   // buffer and handshake
   // ****************************************
   logic [7:0] q[$];
   logic [7:0] hd;
   logic [1:0] st;
   logic [2:0] cnt;
   logic       dir_d;
   wire        go = !dly || cnt == 3'h0;
   // floating bus shows a changing pattern so stale data never passes
   assign dq  = oe_n ? {5'h15, cnt} : hd;
   assign c3r = {c3w[3:1], gin};
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         q.delete();
         st  <= 0;
         cnt <= 0;
         rdy <= 1;
         dac <= 0;
      end else begin
         cnt <= cnt + 1;
         if (!clr_n) begin
            q.delete();
            st  <= 0;
            dac <= 0;
            rdy <= 1;
         end else if (dir != dir_d) begin
            // a turned link restarts its handshake idle
            st  <= 0;
            dac <= 0;
            rdy <= !dir || q.size() < DEPTH;
         end else if (go && dir) begin
            if (st == 0 && rdy && !ack) begin
               q.push_back(bus);
               st  <= 1;
               rdy <= 0;
               dac <= !two;
            end else if (st == 0) begin
               rdy <= q.size() < DEPTH;
            end else if (ack) begin
               st  <= 0;
               dac <= 0;
            end
         end else if (go) begin
            if (st == 0 && q.size() > 0 && (two || lrdy)) begin
               rdy <= 0;
               st  <= 1;
            end else if (st == 1 && ack != two) begin
               q.pop_front();
               rdy <= 1;
               st  <= 2;
            end else if (st == 2 && ack == two) begin
               st <= 0;
            end
         end
      end
      full  <= q.size() == DEPTH;
      empty <= q.size() == 0;
      hd    <= q.size() > 0 ? q[0] : 8'h00;
      dir_d <= dir;
   end
endmodule // fifo_dev_model
`default_nettype wire

// ===== tb/hs_ctrl_test.sv
// self-checking testbench of the handshake controller
`timescale 1ns/1ps
`default_nettype none
`include "hs_ctrl_map.vh"
module hs_ctrl_test;
   // ****************************************
   // nets and instances
   // ****************************************
   logic        CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, dly = 0, two = 0, er;
   logic [7:0]  PADDR = 0;
   logic [31:0] PWDATA = 0, rv;
   logic [3:0]  c3w = 0;
   wire  [31:0] PRDATA;
   wire  [7:0]  DATA_IN, DATA_OUT, dq;
   wire  [3:0]  c3r;
   wire PREADY, PSLVERR, IRQ, DATA_OE, OE_N, READY_OR_AVAILABLE_OUT, VALID_OR_ACCEPTED_IN, dac;
   wire ACCEPTED_OR_LISTENER_READY_IN, ACCEPTED_OR_LISTENER_READY_OUT, ACCEPTED_OR_LISTENER_READY_OE;
   wire FULL, EMPTY, CLEAR_IN, CLEAR_OUT, CLEAR_OE, DATA_DIR_IN, DATA_DIR_OUT, DATA_DIR_OE;
   wire GENERAL_INPUT_BIT0, GENERAL_OUTPUT_BIT1, GENERAL_OUTPUT_BIT3;
   int num_errors = 0, n_compared = 0;
   assign DATA_IN = DATA_OE ? DATA_OUT : dq;
   assign ACCEPTED_OR_LISTENER_READY_IN = ACCEPTED_OR_LISTENER_READY_OE ? ACCEPTED_OR_LISTENER_READY_OUT : dac;
   assign CLEAR_IN = CLEAR_OE ? CLEAR_OUT : 1'b1; // pulled up
   assign DATA_DIR_IN = DATA_DIR_OE & DATA_DIR_OUT; // pulled down when undriven
   assign GENERAL_OUTPUT_BIT1 = c3r[1];
   assign GENERAL_OUTPUT_BIT3 = c3r[3];
   hs_ctrl u_dut (.*);
   fifo_dev_model u_dev (.clk(CLK_SYS), .rst(RST), .dly(dly), .two(two), .c3w(c3w), .bus(DATA_IN), .oe_n(OE_N),
      .ack(VALID_OR_ACCEPTED_IN), .lrdy(ACCEPTED_OR_LISTENER_READY_IN), .clr_n(CLEAR_IN), .dir(DATA_DIR_IN),
      .gin(GENERAL_INPUT_BIT0), .rdy(READY_OR_AVAILABLE_OUT), .dac(dac), .dq(dq), .full(FULL), .empty(EMPTY),
      .c3r(c3r));
   initial forever #10 CLK_SYS = ~CLK_SYS;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1;
      do begin
         @(posedge CLK_SYS);
      end while (PREADY !== 1'b1);
      rv = PRDATA;
      er = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic poll(input logic [7:0] a, input int b);
      int k;
      k = 0;
      do begin
         rd(a);
         k++;
      end while (rv[b] !== 1'b1 && k < 300);
      chk(rv[b], 1);
   endtask
   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd(`OFS_CTRL);
      chk(rv, 0);
      rd(`OFS_INT_MASK);
      chk(rv, 0);
      rd(`OFS_INT_STAT);
      chk(rv, 0);
      rd(8'h18);
      chk(er, 1);
      chk(rv, 0);
      chk(OE_N, 1);
      $display("reset and map done");
   endtask
   task automatic t_tx(input logic tw, input logic [7:0] d);
      two <= tw;
      wr(`OFS_CTRL, 32'h13 | {tw, 2'b00});
      wr(`OFS_TXDATA, {24'h0, d});
      wr(`OFS_TXDATA, 32'h0);
      chk(er, 1);
      poll(`OFS_INT_STAT, `IRQ_TX_DONE);
      chk(u_dev.q[$], d);
      chk(IRQ, 1);
      wr(`OFS_INT_STAT, 32'hF);
      @(posedge CLK_SYS);
      chk(IRQ, 0);
      $display("send %h done", d);
   endtask
   task automatic t_rx(input logic tw, input logic [7:0] d);
      two <= tw;
      wr(`OFS_CTRL, 32'h11 | {tw, 2'b00});
      poll(`OFS_INT_STAT, `IRQ_RX_DONE);
      // stop the port before the read frees it, so no byte starts under the old mode
      wr(`OFS_CTRL, 32'h10 | {tw, 2'b00});
      poll(`OFS_STATUS, `ST_RX_VALID);
      rd(`OFS_RXDATA);
      chk(rv, d);
      chk(IRQ, 0);
      wr(`OFS_INT_STAT, 32'hF);
      $display("receive %h done", d);
   endtask
   task automatic t_clear;
      two <= 0;
      wr(`OFS_CTRL, 32'h13);
      wr(`OFS_TXDATA, 32'h77);
      poll(`OFS_INT_STAT, `IRQ_TX_DONE);
      rd(`OFS_STATUS);
      chk(rv[`ST_DIR_PIN], 1);
      wr(`OFS_CTRL, 32'h1B);
      poll(`OFS_STATUS, `ST_EMPTY);
      chk(u_dev.q.size(), 0);
      chk({rv[`ST_CLEAR_PIN], rv[`ST_BUSY]}, 0);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_INT_STAT, 32'hF);
      $display("clear done");
   endtask
   task automatic t_gen;
      for (int i = 0; i < 2; i++) begin
         c3w <= {i[0], 1'b0, i[0], 1'b0};
         wr(`OFS_CTRL, {26'h0, i[0], 5'h0});
         rd(`OFS_STATUS);
         rd(`OFS_STATUS);
         chk(c3r[0], i);
         chk(rv[5:4], {i[0], i[0]});
      end
      $display("general lines done");
   endtask
   initial begin
      #400000;
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge CLK_SYS);
      RST <= 0;
      t_reset();
      wr(`OFS_INT_MASK, 32'h1);
      t_tx(0, 8'h3C);
      t_tx(0, 8'hA5);
      t_tx(0, 8'h01);
      dly <= 1;
      t_tx(1, 8'hFF);
      rd(`OFS_STATUS);
      chk(rv[`ST_FULL], 1);
      t_rx(0, 8'h3C);
      t_rx(0, 8'hA5);
      t_rx(1, 8'h01);
      t_rx(1, 8'hFF);
      dly <= 0;
      rd(`OFS_STATUS);
      chk(rv[`ST_EMPTY], 1);
      t_clear();
      t_gen();
      stop_test();
   end
endmodule // hs_ctrl_test
`default_nettype wire
